// ### core/vector_ack_strobe_glue_pkg.sv
// Constants for the acknowledge-cycle glue and its peripheral side
// Function
// - Fetch active with memory request idle at second bus state starts acknowledge.
// - Acknowledge strobe asserts on the rising edge of the second bus state.
// - Glue generates both acknowledge strobe and acknowledge read strobe itself.
// - Outside acknowledge the shift chain is clear; other logic drives read and wait.
// - Ordinary cycles derive peripheral read/write strobes from system strobes.
// - Vector driven on data bus only while acknowledge and read both active.
// - Processor waits until vector valid; extra delay from later shift stage.
// - Chain uses pending flags only during acknowledge; commands clear in-service.
// - Read and write strobes low together reset the peripheral.
// - After reset line status reads 01xxx100b with pin bits 5, 4, 3.
// - Both time-constant registers and status enable register read back writes.
// - Eight-bit vector from vector register, unmodified with status insert off.
// - Request raised only with pending flag, master enable and chain input set; source enable only gates latching of the pending flag.
// - With 20h, 01h and 08h enabled, any clear-to-send change interrupts.
// - Command 10h resets status latch; 38h clears highest in-service flag.
// - Writing 0C0h to master control acts as the hardware reset.
// - Acknowledge read lets the winning device drive vector and set in-service.
package vector_ack_strobe_glue_pkg;

    localparam int MCLK_PERIOD_NS = 50;
    localparam int ACK_TO_RD_NS   = 125;
    localparam int VEC_VALID_NS   = 120;
    // Least times round up to whole clocks
    localparam int ACK_TO_RD_CYC  =
        (ACK_TO_RD_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
    localparam int VEC_VALID_CYC  =
        (VEC_VALID_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Register numbers on reg_index
    localparam logic [3:0] REG_COMMAND     = 4'h0;
    localparam logic [3:0] REG_IRQ_MODE    = 4'h1;
    localparam logic [3:0] REG_VECTOR      = 4'h2;
    localparam logic [3:0] REG_MASTER_CTRL = 4'h9;
    localparam logic [3:0] REG_BAUD_LOW    = 4'hc;
    localparam logic [3:0] REG_BAUD_HIGH   = 4'hd;
    localparam logic [3:0] REG_EXT_ENABLE  = 4'hf;

    // Command and control codes
    localparam logic [7:0] CMD_RESET_EXT_STATUS = 8'h10;
    localparam logic [7:0] CMD_RESET_HIGHEST_IS = 8'h38;
    localparam logic [7:0] MASTER_SOFT_RESET    = 8'hc0;

    // Field positions
    localparam int EXT_IRQ_EN_BIT  = 0;  // irq mode register
    localparam int MIE_BIT         = 3;  // master control register
    localparam int VIS_BIT         = 0;  // master control register
    localparam int CTS_IRQ_EN_BIT  = 5;  // ext/status enable register
    localparam int LS_CTS_BIT      = 5;
    localparam int LS_SYNC_BIT     = 4;
    localparam int LS_DCD_BIT      = 3;

    // Fixed line status bits: 6 and 2 set, 7, 1, 0 clear
    localparam logic [7:0] LINE_STATUS_FIXED = 8'h44;
    localparam logic [2:0] VIS_EXT_STATUS_CODE = 3'h5;

    // Values after reset
    localparam logic [7:0] RST_VECTOR     = 8'h00;
    localparam logic [7:0] RST_IRQ_MODE   = 8'h00;
    localparam logic [7:0] RST_MASTER     = 8'h00;
    localparam logic [7:0] RST_BAUD       = 8'h00;
    localparam logic [7:0] RST_EXT_ENABLE = 8'h00;

endpackage : vector_ack_strobe_glue_pkg

// ### core/ack_shift_chain.sv
// Serial-in shift chain that sequences one acknowledge cycle
`timescale 1ns/1ps
module ack_shift_chain #(
    parameter int DEPTH = 7
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             serial_in,
    output logic      [DEPTH-1:0] stages
);

    logic [DEPTH-1:0] chain_q;
    logic [DEPTH-1:0] chain_d;

    always_comb begin
        if (clear) begin
            chain_d = '0;
        end else begin
            chain_d = {chain_q[DEPTH-2:0], serial_in};
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= chain_d;
        end
    end

    assign stages = chain_q;

endmodule : ack_shift_chain

// ### core/vector_ack_strobe_cycle_glue.sv
// Acknowledge-cycle glue plus the peripheral's acknowledge-side logic
`timescale 1ns/1ps
module vector_ack_strobe_cycle_glue #(
    parameter int RD_TAP   = vector_ack_strobe_glue_pkg::ACK_TO_RD_CYC,
    parameter int WAIT_TAP = vector_ack_strobe_glue_pkg::ACK_TO_RD_CYC
                           + vector_ack_strobe_glue_pkg::VEC_VALID_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       opcode_fetch_cycle_n,
    input  wire logic       memory_request_n,
    input  wire logic       sys_rd_n,
    input  wire logic       sys_wr_n,
    input  wire logic       periph_sel_n,
    input  wire logic       sys_reset,
    input  wire logic       other_wait,
    input  wire logic [3:0] reg_index,
    input  wire logic [7:0] data_in,
    output logic      [7:0] data_out,
    output logic            data_oe,
    output logic            vector_ack_strobe_n,
    output logic            periph_read_strobe_n,
    output logic            periph_write_strobe_n,
    output logic            wait_n,
    input  wire logic       cts_pin_n,
    input  wire logic       sync_pin_n,
    input  wire logic       carrier_detect_input_n,
    input  wire logic       chain_enable_in,
    output logic            chain_enable_out,
    output logic            irq_request_n
);

    localparam int DEPTH = WAIT_TAP + 1;
    localparam int NPIN  = 4;

    // ****************************************************************
    // Acknowledge sequencer
    // ****************************************************************
    logic [DEPTH-1:0] stages;
    logic             fetch_active;
    logic             ack_detect;
    logic             ack_on;
    logic             ack_rd;
    logic             ack_wait;

    assign fetch_active = !opcode_fetch_cycle_n;
    // Fetch without memory request can only be the acknowledge cycle
    assign ack_detect   = fetch_active && memory_request_n;

    ack_shift_chain #(
        .DEPTH     (DEPTH)
    ) u_chain (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .clear     (!fetch_active),
        .serial_in (ack_detect),
        .stages    (stages)
    );

    assign ack_on   = stages[0];
    // A later tap buys daisy-chain settling in whole clocks
    assign ack_rd   = stages[RD_TAP];
    assign ack_wait = stages[0] && !stages[WAIT_TAP];

    // ****************************************************************
    // Strobe generation
    // ****************************************************************
    logic io_rd;
    logic io_wr;
    logic rd_active;
    logic wr_active;

    assign io_rd     = !sys_rd_n && !periph_sel_n;
    assign io_wr     = !sys_wr_n && !periph_sel_n;
    // Reset drives both strobes low at once
    assign rd_active = io_rd || ack_rd || sys_reset;
    assign wr_active = io_wr || sys_reset;

    assign vector_ack_strobe_n   = !ack_on;
    assign periph_read_strobe_n  = !rd_active;
    assign periph_write_strobe_n = !wr_active;
    assign wait_n                = !(ack_wait || other_wait);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] s1_q;
    logic [NPIN-1:0] s2_q;
    logic [NPIN-1:0] s3_q;
    logic [NPIN-1:0] pin_q;
    logic [NPIN-1:0] pin_d;

    assign pin_raw = {chain_enable_in, carrier_detect_input_n,
                      sync_pin_n, cts_pin_n};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_comb begin
                // Only a level seen twice in a row is taken
                pin_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : pin_q[gi];
            end
            always_ff @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[gi]  <= 1'b0;
                    s2_q[gi]  <= 1'b0;
                    s3_q[gi]  <= 1'b0;
                    pin_q[gi] <= 1'b0;
                end else begin
                    s1_q[gi]  <= pin_raw[gi];
                    s2_q[gi]  <= s1_q[gi];
                    s3_q[gi]  <= s2_q[gi];
                    pin_q[gi] <= pin_d[gi];
                end
            end
        end
    endgenerate

    logic cts_n_s;
    logic sync_n_s;
    logic dcd_n_s;
    logic chain_in_s;

    assign cts_n_s    = pin_q[0];
    assign sync_n_s   = pin_q[1];
    assign dcd_n_s    = pin_q[2];
    assign chain_in_s = pin_q[3];

    // ****************************************************************
    // Peripheral registers and interrupt state
    // ****************************************************************
    logic [7:0] irq_mode_q;
    logic [7:0] irq_mode_d;
    logic [7:0] vector_q;
    logic [7:0] vector_d;
    logic [7:0] master_q;
    logic [7:0] master_d;
    logic [7:0] baud_lo_q;
    logic [7:0] baud_lo_d;
    logic [7:0] baud_hi_q;
    logic [7:0] baud_hi_d;
    logic [7:0] ext_en_q;
    logic [7:0] ext_en_d;
    logic       irq_pending_flag_q;
    logic       irq_pending_flag_d;
    logic       in_service_flag_q;
    logic       in_service_flag_d;
    logic       cts_last_q;
    logic       cts_last_d;
    logic       wr_last_q;
    logic       wr_last_d;
    logic       ack_rd_last_q;
    logic       ack_rd_last_d;
    logic       chain_won_q;
    logic       chain_won_d;
    logic [7:0] data_out_q;
    logic [7:0] data_out_d;

    logic       periph_reset;
    logic       wr_start;
    logic       cmd_wr;
    logic       soft_reset;
    logic       cts_change;
    logic       src_enable;
    logic       master_irq_enable;
    logic       selected;
    logic       ack_read_start;
    logic [7:0] line_status;
    logic [7:0] vector_out;

    assign periph_reset = rd_active && wr_active;
    // A write counts once, at the strobe's leading clock
    assign wr_start     = io_wr && !wr_last_q && !periph_reset;
    assign cmd_wr       = wr_start && (reg_index ==
                                       vector_ack_strobe_glue_pkg::REG_COMMAND);
    assign soft_reset   = wr_start
                       && (reg_index == vector_ack_strobe_glue_pkg::REG_MASTER_CTRL)
                       && (data_in == vector_ack_strobe_glue_pkg::MASTER_SOFT_RESET);
    assign master_irq_enable          = master_q[vector_ack_strobe_glue_pkg::MIE_BIT];
    assign src_enable   = ext_en_q[vector_ack_strobe_glue_pkg::CTS_IRQ_EN_BIT]
                       && irq_mode_q[vector_ack_strobe_glue_pkg::EXT_IRQ_EN_BIT];
    assign cts_change   = (cts_n_s != cts_last_q) && src_enable;
    // This device wins the chain when it is pending and not blocked
    assign selected     = chain_in_s && irq_pending_flag_q
                       && !in_service_flag_q;
    assign ack_read_start = ack_on && ack_rd && !ack_rd_last_q;

    always_comb begin
        line_status = vector_ack_strobe_glue_pkg::LINE_STATUS_FIXED;
        line_status[vector_ack_strobe_glue_pkg::LS_CTS_BIT]  = cts_n_s;
        line_status[vector_ack_strobe_glue_pkg::LS_SYNC_BIT] = sync_n_s;
        line_status[vector_ack_strobe_glue_pkg::LS_DCD_BIT]  = dcd_n_s;
    end

    always_comb begin
        vector_out = vector_q;
        if (master_q[vector_ack_strobe_glue_pkg::VIS_BIT]) begin
            vector_out[3:1] = vector_ack_strobe_glue_pkg::VIS_EXT_STATUS_CODE;
        end
    end

    always_comb begin
        irq_mode_d         = irq_mode_q;
        vector_d           = vector_q;
        master_d           = master_q;
        baud_lo_d          = baud_lo_q;
        baud_hi_d          = baud_hi_q;
        ext_en_d           = ext_en_q;
        irq_pending_flag_d = irq_pending_flag_q;
        in_service_flag_d  = in_service_flag_q;
        cts_last_d         = cts_n_s;
        wr_last_d          = io_wr;
        ack_rd_last_d      = ack_on && ack_rd;
        // Remembers that this acknowledge was won here, not an older one
        chain_won_d        = ack_on && (chain_won_q
                                        || (ack_read_start && selected));
        if (wr_start) begin
            unique case (reg_index)
                vector_ack_strobe_glue_pkg::REG_IRQ_MODE:    irq_mode_d = data_in;
                vector_ack_strobe_glue_pkg::REG_VECTOR:      vector_d   = data_in;
                vector_ack_strobe_glue_pkg::REG_MASTER_CTRL: master_d   = data_in;
                vector_ack_strobe_glue_pkg::REG_BAUD_LOW:    baud_lo_d  = data_in;
                vector_ack_strobe_glue_pkg::REG_BAUD_HIGH:   baud_hi_d  = data_in;
                vector_ack_strobe_glue_pkg::REG_EXT_ENABLE:  ext_en_d   = data_in;
                default: begin
                end
            endcase
        end
        if (cmd_wr && data_in == vector_ack_strobe_glue_pkg::CMD_RESET_HIGHEST_IS) begin
            in_service_flag_d = 1'b0;
        end
        if (cmd_wr && data_in == vector_ack_strobe_glue_pkg::CMD_RESET_EXT_STATUS) begin
            irq_pending_flag_d = 1'b0;
        end
        // A pin change in the clearing cycle still latches
        if (cts_change) begin
            irq_pending_flag_d = 1'b1;
        end
        if (ack_read_start && selected) begin
            in_service_flag_d = 1'b1;
        end
        if (soft_reset) begin
            irq_mode_d         = vector_ack_strobe_glue_pkg::RST_IRQ_MODE;
            vector_d           = vector_ack_strobe_glue_pkg::RST_VECTOR;
            master_d           = vector_ack_strobe_glue_pkg::RST_MASTER;
            baud_lo_d          = vector_ack_strobe_glue_pkg::RST_BAUD;
            baud_hi_d          = vector_ack_strobe_glue_pkg::RST_BAUD;
            ext_en_d           = vector_ack_strobe_glue_pkg::RST_EXT_ENABLE;
            irq_pending_flag_d = 1'b0;
            in_service_flag_d  = 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mode_q         <= vector_ack_strobe_glue_pkg::RST_IRQ_MODE;
            vector_q           <= vector_ack_strobe_glue_pkg::RST_VECTOR;
            master_q           <= vector_ack_strobe_glue_pkg::RST_MASTER;
            baud_lo_q          <= vector_ack_strobe_glue_pkg::RST_BAUD;
            baud_hi_q          <= vector_ack_strobe_glue_pkg::RST_BAUD;
            ext_en_q           <= vector_ack_strobe_glue_pkg::RST_EXT_ENABLE;
            irq_pending_flag_q <= 1'b0;
            in_service_flag_q  <= 1'b0;
            cts_last_q         <= 1'b0;
            wr_last_q          <= 1'b0;
            ack_rd_last_q      <= 1'b0;
            chain_won_q        <= 1'b0;
        end else if (periph_reset) begin
            irq_mode_q         <= vector_ack_strobe_glue_pkg::RST_IRQ_MODE;
            vector_q           <= vector_ack_strobe_glue_pkg::RST_VECTOR;
            master_q           <= vector_ack_strobe_glue_pkg::RST_MASTER;
            baud_lo_q          <= vector_ack_strobe_glue_pkg::RST_BAUD;
            baud_hi_q          <= vector_ack_strobe_glue_pkg::RST_BAUD;
            ext_en_q           <= vector_ack_strobe_glue_pkg::RST_EXT_ENABLE;
            irq_pending_flag_q <= 1'b0;
            in_service_flag_q  <= 1'b0;
            cts_last_q         <= cts_last_d;
            wr_last_q          <= wr_last_d;
            ack_rd_last_q      <= 1'b0;
            chain_won_q        <= 1'b0;
        end else begin
            irq_mode_q         <= irq_mode_d;
            vector_q           <= vector_d;
            master_q           <= master_d;
            baud_lo_q          <= baud_lo_d;
            baud_hi_q          <= baud_hi_d;
            ext_en_q           <= ext_en_d;
            irq_pending_flag_q <= irq_pending_flag_d;
            in_service_flag_q  <= in_service_flag_d;
            cts_last_q         <= cts_last_d;
            wr_last_q          <= wr_last_d;
            ack_rd_last_q      <= ack_rd_last_d;
            chain_won_q        <= chain_won_d;
        end
    end

    // ****************************************************************
    // Read data, chain and request
    // ****************************************************************
    always_comb begin
        data_out_d = 8'h00;
        if (ack_on) begin
            data_out_d = vector_out;
        end else begin
            unique case (reg_index)
                vector_ack_strobe_glue_pkg::REG_COMMAND:    data_out_d = line_status;
                vector_ack_strobe_glue_pkg::REG_BAUD_LOW:   data_out_d = baud_lo_q;
                vector_ack_strobe_glue_pkg::REG_BAUD_HIGH:  data_out_d = baud_hi_q;
                vector_ack_strobe_glue_pkg::REG_EXT_ENABLE: data_out_d = ext_en_q;
                default:                         data_out_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out_q <= 8'h00;
        end else begin
            data_out_q <= data_out_d;
        end
    end

    assign data_out = data_out_q;
    // Vector only while acknowledge and read overlap, and only if chosen
    assign data_oe  = ack_on ? (ack_rd && (selected || chain_won_q))
                             : io_rd;

    // Pending only blocks the chain while an acknowledge is running
    assign chain_enable_out = chain_in_s && !in_service_flag_q
                           && !(ack_on && irq_pending_flag_q);
    assign irq_request_n = !(irq_pending_flag_q && master_irq_enable && chain_in_s
                             && !in_service_flag_q);

endmodule : vector_ack_strobe_cycle_glue

// ### sim/vector_ack_strobe_glue_properties.sv
// Port checks for the acknowledge-cycle glue
`timescale 1ns/1ps
module vector_ack_strobe_glue_checks (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic opcode_fetch_cycle_n,
    input wire logic memory_request_n,
    input wire logic sys_rd_n,
    input wire logic sys_wr_n,
    input wire logic periph_sel_n,
    input wire logic sys_reset,
    input wire logic other_wait,
    input wire logic chain_enable_in,
    input wire logic vector_ack_strobe_n,
    input wire logic periph_read_strobe_n,
    input wire logic periph_write_strobe_n,
    input wire logic wait_n,
    input wire logic data_oe,
    input wire logic chain_enable_out
);
    // ********************
    // Properties
    // ********************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // First cycle of acknowledge seen with no foreign read in flight
    sequence s_ack_open;
        $fell(vector_ack_strobe_n) && sys_rd_n && !sys_reset;
    endsequence

    chk_ack_start: assert property (
        !opcode_fetch_cycle_n && vector_ack_strobe_n
        |=> vector_ack_strobe_n == !$past(memory_request_n))
        else $error("acknowledge strobe start wrong");
    chk_ack_release: assert property (
        opcode_fetch_cycle_n |=> vector_ack_strobe_n)
        else $error("acknowledge strobe not released");
    chk_rd_held: assert property (
        s_ack_open |-> periph_read_strobe_n [*3])
        else $error("acknowledge read too early");
    chk_rd_opens: assert property (
        s_ack_open ##0 (!opcode_fetch_cycle_n) [*3]
        |=> !periph_read_strobe_n)
        else $error("acknowledge read missing");
    chk_wait_ends: assert property (
        s_ack_open ##0 (!opcode_fetch_cycle_n && !other_wait) [*7]
        |-> wait_n)
        else $error("wait not released");
    chk_idle_rd: assert property (
        vector_ack_strobe_n && !sys_reset
        |-> periph_read_strobe_n == (sys_rd_n || periph_sel_n))
        else $error("idle read strobe wrong");
    chk_wr_follows: assert property (
        periph_write_strobe_n
        == ((sys_wr_n || periph_sel_n) && !sys_reset))
        else $error("write strobe wrong");
    chk_vec_gate: assert property (
        data_oe |-> !periph_read_strobe_n)
        else $error("data driven without read");
    chk_chain_cut: assert property (
        (!chain_enable_in) [*5] |-> !chain_enable_out)
        else $error("chain out high with chain in low");
endmodule : vector_ack_strobe_glue_checks

bind vector_ack_strobe_cycle_glue vector_ack_strobe_glue_checks i_chk (
    .mclk, .rst_n, .opcode_fetch_cycle_n, .memory_request_n,
    .sys_rd_n, .sys_wr_n, .periph_sel_n, .sys_reset, .other_wait,
    .chain_enable_in, .vector_ack_strobe_n, .periph_read_strobe_n,
    .periph_write_strobe_n, .wait_n, .data_oe, .chain_enable_out
);

// ### sim/cpu_bus_model.sv
// Processor bus model: register cycles and vectored acknowledge
`timescale 1ns/1ps
module cpu_bus_model (
    input  wire logic       mclk,
    input  wire logic       wait_n,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic            opcode_fetch_cycle_n,
    output logic            memory_request_n,
    output logic            sys_rd_n,
    output logic            sys_wr_n,
    output logic            periph_sel_n,
    output logic      [3:0] reg_index,
    output logic      [7:0] data_in
);
    // ********************
    // Bus cycles
    // ********************
    initial begin
        {opcode_fetch_cycle_n, memory_request_n} = 2'h3;
        {sys_rd_n, sys_wr_n, periph_sel_n} = 3'h7;
        reg_index = 4'h0;
        data_in = 8'h00;
    end

    task automatic io_cycle(input logic wr, input logic [3:0] r,
                            input logic [7:0] d, output logic [7:0] q);
        @(negedge mclk);
        periph_sel_n = 1'b0;
        reg_index = r;
        data_in = d;
        sys_rd_n = wr;
        sys_wr_n = !wr;
        repeat (3) @(posedge mclk);
        q = data_oe ? data_out : ~data_out;
        @(negedge mclk);
        {sys_rd_n, sys_wr_n, periph_sel_n} = 3'h7;
        // A released bus must not keep showing the old value
        data_in = ~d;
    endtask : io_cycle

    task automatic int_ack(input logic memory_request_idle, input int hold,
                           output logic [7:0] v);
        int n;
        @(negedge mclk);
        opcode_fetch_cycle_n = 1'b0;
        memory_request_n = memory_request_idle;
        repeat (2) @(posedge mclk);
        // Stay in wait states while the chain settles
        for (n = 0; n < 20 && !wait_n; n++) @(posedge mclk);
        v = data_oe ? data_out : ~data_out;
        repeat (hold) @(posedge mclk);
        @(negedge mclk);
        {opcode_fetch_cycle_n, memory_request_n} = 2'h3;
    endtask : int_ack
endmodule : cpu_bus_model

// ### sim/test_vector_ack_strobe_cycle_glue.sv
// Self-checking bench for the acknowledge-cycle glue
`timescale 1ns/1ps
module test_vector_ack_strobe_cycle_glue;
    // ********************
    // Signals and instances
    // ********************
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic sys_reset = 1'b0;
    logic other_wait = 1'b0;
    logic cts_pin_n = 1'b1;
    logic sync_pin_n = 1'b1;
    logic carrier_detect_input_n = 1'b1;
    logic chain_enable_in = 1'b1;
    logic opcode_fetch_cycle_n, memory_request_n, sys_rd_n, sys_wr_n;
    logic periph_sel_n, data_oe, vector_ack_strobe_n, wait_n;
    logic periph_read_strobe_n, periph_write_strobe_n;
    logic chain_enable_out, irq_request_n;
    logic [3:0]  reg_index;
    logic [7:0]  data_in, data_out, q, vec;
    logic [31:0] seed = 32'hebf4_1171;
    logic [3:0]  rb_reg [3] = '{vector_ack_strobe_glue_pkg::REG_BAUD_LOW,
        vector_ack_strobe_glue_pkg::REG_BAUD_HIGH, vector_ack_strobe_glue_pkg::REG_EXT_ENABLE};
    int          failures = 0;
    int          num_checks = 0;
    int          cycles = 0;

    vector_ack_strobe_cycle_glue i_dut (.*);
    cpu_bus_model i_cpu (.mclk, .wait_n, .data_out, .data_oe,
        .opcode_fetch_cycle_n, .memory_request_n, .sys_rd_n, .sys_wr_n,
        .periph_sel_n, .reg_index, .data_in);

    always #25 mclk = ~mclk;

    // Run is a few hundred cycles; this ceiling only catches a hang
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            give_verdict();
        end
    end

    // ********************
    // Helpers
    // ********************
    function automatic logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction : xs

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [3:0] r, input logic [7:0] d);
        logic [7:0] unused;
        i_cpu.io_cycle(1'b1, r, d, unused);
    endtask : wr

    task automatic rd(input logic [3:0] r, output logic [7:0] d);
        i_cpu.io_cycle(1'b0, r, 8'h00, d);
    endtask : rd

    task automatic toggle_cts;
        @(negedge mclk);
        cts_pin_n = !cts_pin_n;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask : toggle_cts

    task give_verdict;
        if (failures == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : give_verdict

    // ********************
    // Scenarios
    // ********************
    initial begin
        repeat (6) @(posedge mclk);
        @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            @(negedge mclk);
            {cts_pin_n, sync_pin_n, carrier_detect_input_n} = seed[2:0];
            repeat (6) @(posedge mclk);
            rd(vector_ack_strobe_glue_pkg::REG_COMMAND, q);
            check(q, {2'b01, seed[2:0], 3'b100});
        end
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            wr(rb_reg[i], seed[7:0]);
            rd(rb_reg[i], q);
            check(q, seed[7:0]);
        end
        rd(4'h5, q);
        check(q, 8'h00);
        wr(vector_ack_strobe_glue_pkg::REG_MASTER_CTRL,
           vector_ack_strobe_glue_pkg::MASTER_SOFT_RESET);
        rd(vector_ack_strobe_glue_pkg::REG_BAUD_LOW, q);
        check(q, vector_ack_strobe_glue_pkg::RST_BAUD);
        seed = xs(seed);
        vec = seed[7:0];
        wr(vector_ack_strobe_glue_pkg::REG_VECTOR, vec);
        wr(vector_ack_strobe_glue_pkg::REG_EXT_ENABLE, 8'h20);
        wr(vector_ack_strobe_glue_pkg::REG_IRQ_MODE, 8'h01);
        wr(vector_ack_strobe_glue_pkg::REG_MASTER_CTRL, 8'h08);
        check({7'h00, irq_request_n}, 8'h01);
        toggle_cts();
        check({7'h00, irq_request_n}, 8'h00);
        i_cpu.int_ack(1'b1, 0, q);
        check(q, vec);
        repeat (2) @(negedge mclk);
        check({7'h00, irq_request_n}, 8'h01);
        wr(vector_ack_strobe_glue_pkg::REG_COMMAND,
           vector_ack_strobe_glue_pkg::CMD_RESET_EXT_STATUS);
        wr(vector_ack_strobe_glue_pkg::REG_COMMAND,
           vector_ack_strobe_glue_pkg::CMD_RESET_HIGHEST_IS);
        check({7'h00, irq_request_n}, 8'h01);
        chain_enable_in = 1'b0;
        toggle_cts();
        check({7'h00, irq_request_n}, 8'h01);
        chain_enable_in = 1'b1;
        repeat (8) @(negedge mclk);
        check({7'h00, irq_request_n}, 8'h00);
        vec = {vec[7:4], vector_ack_strobe_glue_pkg::VIS_EXT_STATUS_CODE, vec[0]};
        wr(vector_ack_strobe_glue_pkg::REG_MASTER_CTRL, 8'h09);
        i_cpu.int_ack(1'b1, 0, q);
        check(q, vec);
        other_wait = 1'b1;
        @(negedge mclk);
        check({7'h00, wait_n}, 8'h00);
        other_wait = 1'b0;
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            i_cpu.int_ack(seed[0], int'(seed[3:1]), q);
            // Already in service: a later acknowledge must not see it drive
            if (seed[0]) check(q, ~vec);
        end
        @(negedge mclk);
        sys_reset = 1'b1;
        @(negedge mclk);
        sys_reset = 1'b0;
        rd(vector_ack_strobe_glue_pkg::REG_EXT_ENABLE, q);
        check(q, vector_ack_strobe_glue_pkg::RST_EXT_ENABLE);
        give_verdict();
    end
endmodule : test_vector_ack_strobe_cycle_glue
